// >>> shared/cmp_ctrl_pkg.sv
`default_nettype none
package cmp_ctrl_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_CONTROL   = 12'h000;
  localparam logic [11:0] OFF_MASK_SRC  = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT  = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h00C;
  // control field positions
  localparam int CTL_ON       = 15;
  localparam int CTL_OE       = 14;
  localparam int CTL_INV      = 13;
  localparam int CTL_EVT      = 9;
  localparam int CTL_RES      = 8;
  localparam int CTL_EDGE_LO  = 6;
  localparam int CTL_REF      = 4;
  localparam int CTL_CH_LO    = 0;
  // writable bit masks
  localparam logic [15:0] CTL_WMASK  = 16'hE2D3;
  localparam logic [15:0] MSK_WMASK  = 16'h0FFF;
  // reset values
  localparam logic [15:0] CTL_RESET  = 16'h0000;
  localparam logic [15:0] MSK_RESET  = 16'h0000;
  // edge select codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_ANY  = 2'h3;
  // minus channel codes
  localparam logic [1:0] CH_B      = 2'h0;
  localparam logic [1:0] CH_C      = 2'h1;
  localparam logic [1:0] CH_D      = 2'h2;
  localparam logic [1:0] CH_BGAP   = 2'h3;
  // last valid pwm source code (six sources, 0 to 5)
  localparam logic [3:0] PWM_LAST  = 4'h5;
endpackage : cmp_ctrl_pkg
`default_nettype wire

// >>> hw/mask_source_mux.sv
`timescale 1ns/1ps
`default_nettype none
module mask_source_mux (
  // select and sources
  input  wire logic [3:0] sel,
  input  wire logic [5:0] pwm,
  // selected source
  output logic            mask_out
);
  // reserved codes give a low mask
  wire logic in_range;
  assign in_range = (sel <= cmp_ctrl_pkg::PWM_LAST);
  assign mask_out = in_range ? pwm[sel[2:0]] : 1'b0;
endmodule : mask_source_mux
`default_nettype wire

// >>> hw/edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module edge_detect (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // sampled level
  input  wire logic level,
  // edges
  output logic      rise,
  output logic      fall
);
  logic prev_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level;
    end
  end
  assign rise = level & ~prev_ff;
  assign fall = ~level & prev_ff;
endmodule : edge_detect
`default_nettype wire

// >>> hw/comparator_event_ctrl.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// comparator control, event and mask select
//------------------------------------------------------------
module comparator_event_ctrl (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // analog side
  input  wire logic        raw_compare,
  output logic             plus_ref_select,
  output logic [1:0]       minus_channel_select,
  output logic             comparator_on,
  // pwm mask sources
  input  wire logic [5:0]  pwm_outputs,
  output logic             mask_a,
  output logic             mask_b,
  output logic             mask_c,
  // results
  output logic             result_pin,
  output logic             result_pin_oe,
  output logic             trigger,
  output logic             irq
);
  //----------------------------------------------------------
  // registers
  //----------------------------------------------------------
  logic [15:0] ctl_ff;
  logic [15:0] msk_ff;
  logic        irq_stat_ff;
  logic        irq_mask_ff;
  logic        result_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        trig_ff;
  logic        irq_ff;
  logic        pin_ff;
  logic        pin_oe_ff;
  logic        mask_a_ff;
  logic        mask_b_ff;
  logic        mask_c_ff;
  logic        ref_ff;
  logic [1:0]  ch_ff;
  logic        on_ff;

  //----------------------------------------------------------
  // apb decode
  //----------------------------------------------------------
  wire logic setup;
  wire logic wr;
  wire logic hit_ctl;
  wire logic hit_msk;
  wire logic hit_ist;
  wire logic hit_imk;
  wire logic hit_any;
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & pready_ff;
  assign hit_ctl = (paddr == cmp_ctrl_pkg::OFF_CONTROL);
  assign hit_msk = (paddr == cmp_ctrl_pkg::OFF_MASK_SRC);
  assign hit_ist = (paddr == cmp_ctrl_pkg::OFF_IRQ_STAT);
  assign hit_imk = (paddr == cmp_ctrl_pkg::OFF_IRQ_MASK);
  assign hit_any = hit_ctl | hit_msk | hit_ist | hit_imk;

  //----------------------------------------------------------
  // comparator result and events
  //----------------------------------------------------------
  wire logic edge_code_rise;
  wire logic edge_code_fall;
  wire logic rise;
  wire logic fall;
  wire logic polarized;
  wire logic flag;
  wire logic hit_edge;
  wire logic fire;
  wire logic flag_clr;
  wire logic nxt_flag;
  wire logic nxt_irq_stat;
  wire logic nxt_irq_mask;
  wire logic [1:0] edge_sel;

  assign edge_sel  = ctl_ff[cmp_ctrl_pkg::CTL_EDGE_LO +: 2];
  assign flag      = ctl_ff[cmp_ctrl_pkg::CTL_EVT];
  assign polarized = ctl_ff[cmp_ctrl_pkg::CTL_ON]
                   & (raw_compare ^ ctl_ff[cmp_ctrl_pkg::CTL_INV]);

  edge_detect u_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .level   (polarized),
    .rise    (rise),
    .fall    (fall)
  );

  assign edge_code_rise = (edge_sel == cmp_ctrl_pkg::EDGE_RISE)
                        | (edge_sel == cmp_ctrl_pkg::EDGE_ANY);
  assign edge_code_fall = (edge_sel == cmp_ctrl_pkg::EDGE_FALL)
                        | (edge_sel == cmp_ctrl_pkg::EDGE_ANY);
  assign hit_edge = (rise & edge_code_rise) | (fall & edge_code_fall);
  assign fire     = hit_edge & ~flag;
  // software clears the flag by writing zero; an event in the clearing cycle is lost
  assign flag_clr = wr & hit_ctl & ~pwdata[cmp_ctrl_pkg::CTL_EVT];
  assign nxt_flag = fire | (flag & ~flag_clr);
  assign nxt_irq_stat = fire | (irq_stat_ff & ~(wr & hit_ist & pwdata[0]));
  assign nxt_irq_mask = (wr & hit_imk) ? pwdata[0] : irq_mask_ff;

  //----------------------------------------------------------
  // register writes
  //----------------------------------------------------------
  wire logic [15:0] nxt_ctl;
  wire logic [15:0] ctl_wr;
  assign ctl_wr  = (wr & hit_ctl)
                 ? (pwdata[15:0] & cmp_ctrl_pkg::CTL_WMASK)
                 : (ctl_ff & cmp_ctrl_pkg::CTL_WMASK);
  assign nxt_ctl = {ctl_wr[15:10], nxt_flag, result_ff, ctl_wr[7:0]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff <= cmp_ctrl_pkg::CTL_RESET;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msk_ff <= cmp_ctrl_pkg::MSK_RESET;
    end else if (wr & hit_msk) begin
      msk_ff <= pwdata[15:0] & cmp_ctrl_pkg::MSK_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_ff <= 1'b0;
      irq_mask_ff <= 1'b0;
      result_ff   <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_mask_ff <= nxt_irq_mask;
      result_ff   <= polarized;
    end
  end

  //----------------------------------------------------------
  // apb answer
  //----------------------------------------------------------
  wire logic [31:0] rd_mux;
  wire logic        nxt_pready;
  assign rd_mux = hit_ctl ? {16'h0000, ctl_ff} :
                  hit_msk ? {16'h0000, msk_ff} :
                  hit_ist ? {31'h00000000, irq_stat_ff} :
                  hit_imk ? {31'h00000000, irq_mask_ff} :
                  32'h00000000;
  assign nxt_pready = setup;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= setup & ~hit_any;
      prdata_ff  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  //----------------------------------------------------------
  // mask sources
  //----------------------------------------------------------
  wire logic sel_a;
  wire logic sel_b;
  wire logic sel_c;

  mask_source_mux u_mask_a (
    .sel      (msk_ff[3:0]),
    .pwm      (pwm_outputs),
    .mask_out (sel_a)
  );
  mask_source_mux u_mask_b (
    .sel      (msk_ff[7:4]),
    .pwm      (pwm_outputs),
    .mask_out (sel_b)
  );
  mask_source_mux u_mask_c (
    .sel      (msk_ff[11:8]),
    .pwm      (pwm_outputs),
    .mask_out (sel_c)
  );

  //----------------------------------------------------------
  // registered outputs
  //----------------------------------------------------------
  wire logic pin_en;
  assign pin_en = ctl_ff[cmp_ctrl_pkg::CTL_ON] & ctl_ff[cmp_ctrl_pkg::CTL_OE];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_ff   <= 1'b0;
      irq_ff    <= 1'b0;
      pin_ff    <= 1'b0;
      pin_oe_ff <= 1'b0;
      mask_a_ff <= 1'b0;
      mask_b_ff <= 1'b0;
      mask_c_ff <= 1'b0;
      ref_ff    <= 1'b0;
      ch_ff     <= cmp_ctrl_pkg::CH_B;
      on_ff     <= 1'b0;
    end else begin
      trig_ff   <= fire;
      irq_ff    <= nxt_irq_stat & nxt_irq_mask;
      pin_ff    <= pin_en & polarized;
      pin_oe_ff <= pin_en;
      mask_a_ff <= sel_a;
      mask_b_ff <= sel_b;
      mask_c_ff <= sel_c;
      ref_ff    <= nxt_ctl[cmp_ctrl_pkg::CTL_REF];
      ch_ff     <= nxt_ctl[cmp_ctrl_pkg::CTL_CH_LO +: 2];
      on_ff     <= nxt_ctl[cmp_ctrl_pkg::CTL_ON];
    end
  end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign trigger              = trig_ff;
  assign irq                  = irq_ff;
  assign result_pin           = pin_ff;
  assign result_pin_oe        = pin_oe_ff;
  assign mask_a               = mask_a_ff;
  assign mask_b               = mask_b_ff;
  assign mask_c               = mask_c_ff;
  assign plus_ref_select      = ref_ff;
  assign minus_channel_select = ch_ff;
  assign comparator_on        = on_ff;

  //----------------------------------------------------------
  // checks
  //----------------------------------------------------------
  a_flag_blocks: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag |=> !trigger) else $error("trigger while flag set");
  a_flag_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    (hit_edge && !flag) |=> ctl_ff[cmp_ctrl_pkg::CTL_EVT] && trigger)
    else $error("event flag not set");
  a_any_edge: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_sel == cmp_ctrl_pkg::EDGE_ANY && !flag
     && $changed(polarized)) |=> trigger)
    else $error("any change missed");
  a_ref_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 plus_ref_select == $past(nxt_ctl[cmp_ctrl_pkg::CTL_REF]))
    else $error("plus ref mismatch");
  a_ch_route: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 minus_channel_select == $past(nxt_ctl[cmp_ctrl_pkg::CTL_CH_LO +: 2]))
    else $error("minus channel mismatch");
  a_mask_c: assert property (
    @(posedge pclk) disable iff (!presetn)
    (msk_ff[11:8] == 4'h2) |=> mask_c == $past(pwm_outputs[2]))
    else $error("mask c wrong");
  a_mask_b: assert property (
    @(posedge pclk) disable iff (!presetn)
    (msk_ff[7:4] > cmp_ctrl_pkg::PWM_LAST) |=> !mask_b)
    else $error("mask b reserved not low");
  a_unimpl_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctl_ff[12:10] == 3'h0) && (ctl_ff[5] == 1'b0)
    && (msk_ff[15:12] == 4'h0) && (ctl_ff[3:2] == 2'h0))
    else $error("unimplemented bit set");
  a_mask_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (msk_ff[3:0] == 4'h5) |=> mask_a == $past(pwm_outputs[5]))
    else $error("mask a wrong");
  a_pin_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    !result_pin_oe |-> !result_pin) else $error("pin driven while off");
  a_irq_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    irq == (irq_stat_ff && irq_mask_ff)) else $error("irq level wrong");
  a_irq_blocked: assert property (
    @(posedge pclk) disable iff (!presetn)
    flag |=> !$rose(irq_stat_ff)) else $error("irq while flag set");
  a_flag_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    (flag_clr && !fire) |=> !ctl_ff[cmp_ctrl_pkg::CTL_EVT])
    else $error("event flag not cleared");
  a_rise_fires: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_sel == cmp_ctrl_pkg::EDGE_RISE && !flag && rise) |=> trigger)
    else $error("rising edge missed");
  a_fall_fires: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_sel == cmp_ctrl_pkg::EDGE_FALL && !flag && fall) |=> trigger)
    else $error("falling edge missed");
  a_rise_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_sel == cmp_ctrl_pkg::EDGE_RISE && fall) |=> !trigger)
    else $error("falling edge fired on rise code");
  a_fall_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_sel == cmp_ctrl_pkg::EDGE_FALL && rise) |=> !trigger)
    else $error("rising edge fired on fall code");
  a_none_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (edge_sel == cmp_ctrl_pkg::EDGE_NONE) |=> !trigger)
    else $error("trigger with edges off");
  a_result_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##2 ctl_ff[cmp_ctrl_pkg::CTL_RES] == $past(polarized, 2))
    else $error("result bit wrong");
  a_oe_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 result_pin_oe == $past(pin_en)) else $error("pin enable wrong");
  a_mask_c_res: assert property (
    @(posedge pclk) disable iff (!presetn)
    (msk_ff[11:8] > cmp_ctrl_pkg::PWM_LAST) |=> !mask_c)
    else $error("mask c reserved not low");
  a_mask_a_res: assert property (
    @(posedge pclk) disable iff (!presetn)
    (msk_ff[3:0] > cmp_ctrl_pkg::PWM_LAST) |=> !mask_a)
    else $error("mask a reserved not low");
  a_slverr_map: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup && !hit_any) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
endmodule : comparator_event_ctrl
`default_nettype wire

// >>> test/far_side_model.sv
`timescale 1ns/1ps
`default_nettype none
//--------
// analog front end stand-in
//--------
module far_side_model (
  // clock
  input  wire logic        pclk,
  // input selections from the block
  input  wire logic        plus_ref_select,
  input  wire logic [1:0]  minus_channel_select,
  // levels: a, ref, b, c, d, bandgap (8 bits each, low first)
  input  wire logic [47:0] volts,
  // comparison result
  output logic             raw_compare
);
  logic [7:0] v_plus;
  logic [7:0] v_minus;
  assign v_plus  = plus_ref_select ? volts[15:8] : volts[7:0];
  assign v_minus = volts[{minus_channel_select, 3'h0} + 6'h10 +: 8];
  always @(posedge pclk) begin
    raw_compare <= v_plus > v_minus;
  end
endmodule : far_side_model
`default_nettype wire

// >>> test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
//--------
// self-checking bench
//--------
module tb_top;
  logic        pclk        = 1'b0;
  logic        presetn     = 1'b0;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0;
  logic [5:0]  pwm_outputs = 6'h00;
  logic [47:0] volts       = 48'hA06090504000;
  wire  [31:0] prdata;
  wire         pready, pslverr, raw_compare, plus_ref_select;
  wire  [1:0]  minus_channel_select;
  wire         comparator_on, mask_a, mask_b, mask_c;
  wire         result_pin, result_pin_oe, trigger, irq;
  logic [32:0] exp_q[$];
  int          bad_count   = 0;
  int          num_checks  = 0;
  int          trig_count  = 0;
  int          seed        = 32'h3F4A4B10;
  localparam logic [11:0] CTL = cmp_ctrl_pkg::OFF_CONTROL;
  localparam logic [11:0] MSK = cmp_ctrl_pkg::OFF_MASK_SRC;
  localparam logic [11:0] IST = cmp_ctrl_pkg::OFF_IRQ_STAT;
  localparam logic [11:0] IMK = cmp_ctrl_pkg::OFF_IRQ_MASK;
  comparator_event_ctrl u_dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .raw_compare,
    .plus_ref_select, .minus_channel_select, .comparator_on, .pwm_outputs,
    .mask_a, .mask_b, .mask_c, .result_pin, .result_pin_oe, .trigger, .irq);
  far_side_model u_far (.pclk, .plus_ref_select, .minus_channel_select,
    .volts, .raw_compare);
  initial forever #2.5 pclk = ~pclk;
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  task automatic check(input string nm, input logic [32:0] g,
                       input logic [32:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n = 0;
    exp_q.push_back(e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask : rd
  task automatic settle(input int c);
    repeat (c) @(posedge pclk);
    #1;
  endtask : settle
  task automatic set_raw(input logic v);
    @(posedge pclk);
    volts[7:0] <= v ? 8'hFF : 8'h00;
    settle(4);
  endtask : set_raw
  function automatic logic pick(input logic [3:0] k);
    return (k < 4'h6) ? pwm_outputs[k[2:0]] : 1'b0;
  endfunction : pick
  always @(posedge pclk) begin
    if (trigger === 1'b1) trig_count++;
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0)
      check("apb", {pslverr, prdata}, exp_q.pop_front());
  end
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    logic [15:0] c;
    logic [3:0]  k;
    logic        e;
    logic [7:0]  vm;
    int          n0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL, 32'h0);
    rd(MSK, 32'h0);
    wr(CTL, 32'hFFFF7FFF);
    rd(CTL, 32'h000060D3);
    settle(1);
    check("pin_off", 33'(result_pin), 33'h0);
    wr(MSK, 32'hFFFFFFFF);
    rd(MSK, 32'h00000FFF);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 12'h014, 32'hFFFFFFFF, {1'b1, 32'h0});
    @(posedge pclk);
    volts[7:0] <= 8'h80;
    for (int i = 0; i < 8; i++) begin
      c = 16'h8000;
      c[4] = i[2];
      c[1:0] = i[1:0];
      wr(CTL, {16'h0, c});
      settle(4);
      vm = volts[16 + 8 * i[1:0] +: 8];
      c[8] = (i[2] ? 8'h40 : 8'h80) > vm;
      check("ref", 33'(plus_ref_select), 33'(i[2]));
      check("chan", 33'(minus_channel_select), 33'(i[1:0]));
      check("pin_gate", 33'(result_pin), 33'h0);
      check("pin_oe", 33'(result_pin_oe), 33'h0);
      check("on", 33'(comparator_on), 33'h1);
      rd(CTL, {16'h0, c});
    end
    for (int i = 0; i < 8; i++) begin
      k = 4'(i);
      @(posedge pclk);
      pwm_outputs <= 6'($random(seed));
      wr(MSK, {20'h0, k ^ 4'h2, k ^ 4'h1, k});
      settle(3);
      check("mask_a", 33'(mask_a), 33'(pick(k)));
      check("mask_b", 33'(mask_b), 33'(pick(k ^ 4'h1)));
      check("mask_c", 33'(mask_c), 33'(pick(k ^ 4'h2)));
    end
    wr(IMK, 32'h1);
    for (int i = 0; i < 8; i++) begin
      wr(CTL, 32'h0);
      set_raw(i[2]);
      c = 16'hC000;
      c[13] = i[2];
      c[7:6] = i[1:0];
      wr(CTL, {16'h0, c});
      wr(IST, 32'h1);
      settle(1);
      n0 = trig_count;
      e = (i[1:0] != 2'h0);
      for (int j = 0; j < 2; j++) begin
        set_raw(!i[2]);
        check("pin_hi", 33'(result_pin), 33'h1);
        check("pin_oe_on", 33'(result_pin_oe), 33'h1);
        check("trig_r", 33'(trig_count - n0), 33'(j ? e : i[0]));
        set_raw(i[2]);
      end
      check("trigs", 33'(trig_count - n0), 33'(e));
      check("irq", 33'(irq), 33'(e));
      c[9] = e;
      rd(CTL, {16'h0, c});
    end
    wr(IMK, 32'h0);
    settle(2);
    check("irq_masked", 33'(irq), 33'h0);
    rd(IST, 32'h1);
    wr(IST, 32'h1);
    rd(IST, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL, 32'h0);
    rd(MSK, 32'h0);
    check("on_rst", 33'(comparator_on), 33'h0);
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
